// ### logic/serial_port_status_flags_defs.svh
`ifndef SERIAL_PORT_STATUS_FLAGS_DEFS_SVH
`define SERIAL_PORT_STATUS_FLAGS_DEFS_SVH

// Bits per byte minus one: index of the last data bit
`define SPF_LAST_BIT   3'h7
// Bus-clock index of the acknowledge bit
`define SPF_ACK_BIT    4'h8
// Last data bit on the bus-clock bit counter
`define SPF_LAST_SCL   4'h7
`define SPF_CNT_RST    4'h0
`define SPF_FLAG_RST   1'b0
`define SPF_BYTE_RST   8'h00
`define SPF_ADDR_LSB   1
`define SPF_ADDR_MSB   7

`endif

// ### logic/serial_port_status_pkg.sv
package serial_port_status_pkg;

  typedef struct packed {
    logic data_not_address_flag;
    logic stop_seen_flag;
    logic start_seen_flag;
    logic read_not_write_flag;
  } status_s;

  typedef struct packed {
    logic port_enable;
    logic i2c_mode;
    logic master_mode;
    logic clock_idle_polarity;
    logic clock_edge_select;
  } config_s;

endpackage

// ### logic/serial_port_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_status_flags_defs.svh"

module serial_port_status_flags
  import serial_port_status_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int BYTE_W = 8
) (
  // System clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Configuration, held steady while the port is busy
  input  wire config_s           cfg,
  input  wire logic [ADDR_W-1:0] own_address,
  input  wire logic              master_tx_busy,
  // Transmit word
  input  wire logic [BYTE_W-1:0] tx_data,
  input  wire logic              tx_load,
  output logic                   tx_busy_q,
  // Serial clock domain
  input  wire logic              sck,
  output logic                   sdo_q,
  // Bus pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  // Status for software
  output status_s                status_q
);

  logic              rise_sel;
  logic              shift_clk;
  logic [2:0]        link_cnt_q;
  logic              done_t_q;
  logic [BYTE_W-1:0] tx_hold_q;
  logic              done_s1_q;
  logic              done_s2_q;
  logic              done_s3_q;
  logic              scl_s1_q;
  logic              scl_s2_q;
  logic              scl_p_q;
  logic              sda_s1_q;
  logic              sda_s2_q;
  logic              sda_p_q;
  logic              start_det;
  logic              stop_det;
  logic              scl_rise;
  logic [3:0]        bit_cnt_q;
  logic [BYTE_W-1:0] byte_sr_q;
  logic              first_q;
  logic              byte_done;
  logic              addr_match;
  logic              i2c_on;

  // Edge choice must be static: changing it mid-frame glitches the shift clock
  assign rise_sel  = cfg.clock_idle_polarity ^ cfg.clock_edge_select;
  assign shift_clk = sck ^ ~rise_sel;

  // Transmit hold word; stays stable while busy so the link side may read it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_hold_q <= `SPF_BYTE_RST;
    end else if (tx_load && !tx_busy_q) begin
      tx_hold_q <= tx_data;
    end
  end

  // Byte-done toggle returns from the link side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_s1_q <= `SPF_FLAG_RST;
      done_s2_q <= `SPF_FLAG_RST;
      done_s3_q <= `SPF_FLAG_RST;
    end else begin
      done_s1_q <= done_t_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_busy_q <= `SPF_FLAG_RST;
    end else if (tx_load && !tx_busy_q) begin
      tx_busy_q <= 1'b1;
    end else if (done_s2_q ^ done_s3_q) begin
      tx_busy_q <= 1'b0;
    end
  end

  // Link side: one bit out per selected edge, MSB first
  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      link_cnt_q <= 3'h0;
      sdo_q      <= `SPF_FLAG_RST;
      done_t_q   <= `SPF_FLAG_RST;
    end else begin
      sdo_q      <= tx_hold_q[`SPF_LAST_BIT - link_cnt_q];
      link_cnt_q <= 3'(link_cnt_q + 3'h1);
      if (link_cnt_q == `SPF_LAST_BIT) begin
        done_t_q <= ~done_t_q;
      end
    end
  end

  // The previous sample may fall inside reset, where the count is held: skip that one
  a_rise_shift: assert property (@(negedge sck) disable iff (rst)
    (rise_sel && $past(rise_sel) && !$past(rst)) |->
    link_cnt_q == 3'($past(link_cnt_q) + 3'h1))
    else $error("shift count did not advance on the rising edge");
  a_fall_shift: assert property (@(posedge sck) disable iff (rst)
    (!rise_sel && $past(!rise_sel) && !$past(rst)) |->
    link_cnt_q == 3'($past(link_cnt_q) + 3'h1))
    else $error("shift count did not advance on the falling edge");

  // Bus pins pass two flops before any decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q  <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_p_q  <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_p_q  <= sda_s2_q;
    end
  end

  assign i2c_on     = cfg.port_enable && cfg.i2c_mode;
  assign start_det  = i2c_on && scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
  assign stop_det   = i2c_on && scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;
  assign scl_rise   = i2c_on && scl_s2_q && !scl_p_q;
  assign byte_done  = scl_rise && (bit_cnt_q == `SPF_LAST_SCL);
  assign addr_match = byte_sr_q[ADDR_W-1:0] == own_address;

  // Bit and byte tracking; the first byte after Start is the address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= `SPF_CNT_RST;
      byte_sr_q <= `SPF_BYTE_RST;
      first_q   <= `SPF_FLAG_RST;
    end else if (start_det || stop_det || !i2c_on) begin
      bit_cnt_q <= `SPF_CNT_RST;
      first_q   <= start_det;
    end else if (scl_rise) begin
      byte_sr_q <= {byte_sr_q[BYTE_W-2:0], sda_s2_q};
      if (bit_cnt_q == `SPF_ACK_BIT) begin
        bit_cnt_q <= `SPF_CNT_RST;
      end else begin
        bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
      end
      if (byte_done) begin
        first_q <= 1'b0;
      end
    end
  end

  // Start and stop flags: only the most recent condition reads as 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q.start_seen_flag <= `SPF_FLAG_RST;
      status_q.stop_seen_flag  <= `SPF_FLAG_RST;
    end else if (!cfg.port_enable) begin
      status_q.start_seen_flag <= 1'b0;
      status_q.stop_seen_flag  <= 1'b0;
    end else if (start_det) begin
      status_q.start_seen_flag <= 1'b1;
      status_q.stop_seen_flag  <= 1'b0;
    end else if (stop_det) begin
      status_q.start_seen_flag <= 1'b0;
      status_q.stop_seen_flag  <= 1'b1;
    end
  end

  // Data/address indicator updates at the last data bit of each byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q.data_not_address_flag <= `SPF_FLAG_RST;
    end else if (byte_done) begin
      status_q.data_not_address_flag <= !first_q;
    end
  end

  // Read/write indicator; no software write path reaches any flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q.read_not_write_flag <= `SPF_FLAG_RST;
    end else if (i2c_on && cfg.master_mode) begin
      status_q.read_not_write_flag <= master_tx_busy;
    end else if (byte_done && first_q && addr_match) begin
      status_q.read_not_write_flag <= sda_s2_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_sets: assert property (start_det && cfg.port_enable |=>
    status_q.start_seen_flag && !status_q.stop_seen_flag)
    else $error("start flag not set after start");
  a_stop_sets: assert property (stop_det && cfg.port_enable |=>
    status_q.stop_seen_flag && !status_q.start_seen_flag)
    else $error("stop flag not set after stop");
  a_disable_clears: assert property (!cfg.port_enable |=>
    !status_q.stop_seen_flag && !status_q.start_seen_flag)
    else $error("flags not cleared while disabled");
  a_addr_byte: assert property (byte_done && first_q |=>
    !status_q.data_not_address_flag)
    else $error("address byte not flagged as address");
  a_data_byte: assert property (byte_done && !first_q |=>
    status_q.data_not_address_flag)
    else $error("data byte not flagged as data");
  a_slave_rw: assert property (
    byte_done && first_q && addr_match && !cfg.master_mode |=>
    status_q.read_not_write_flag == $past(sda_s2_q))
    else $error("read/write bit not captured on match");
  a_master_rw: assert property (i2c_on && cfg.master_mode |=>
    status_q.read_not_write_flag == $past(master_tx_busy))
    else $error("master read/write flag does not follow transmission");
  a_flags_hold: assert property (
    $changed(status_q.data_not_address_flag) |-> $past(byte_done))
    else $error("data/address flag changed without a byte");
  a_rw_hold: assert property (
    $changed(status_q.read_not_write_flag) |->
    $past(i2c_on && cfg.master_mode) || $past(byte_done && first_q && addr_match))
    else $error("read/write flag changed without a cause");

endmodule // serial_port_status_flags

`default_nettype wire

// ### verification/bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
  // Device side
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic idle,
  input  wire logic sdo_q,
  // Pins driven by the peer
  output logic      sck,
  output logic      scl,
  output logic      sda
);
  logic d_now;
  initial begin
    sck   = 1'b0;
    scl   = 1'b1;
    sda   = 1'b1;
    d_now = 1'b1;
  end
  // A few link edges during reset so the link domain leaves reset cleanly
  always @(rst or idle) begin
    if (rst) begin
      sck = idle;
      repeat (4) #7.5 sck = ~sck;
    end
  end
  // Six cycles between pin moves covers the two-flop synchroniser
  task automatic step(input logic c, input logic d);
    repeat (6) @(posedge clk);
    scl   <= c;
    sda   <= d;
    d_now = d;
  endtask
  task automatic start_cond();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic stop_cond();
    step(1'b0, d_now);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // Ninth bit is the acknowledge slot, left to the pull-up
  task automatic i2c_byte(input logic [7:0] b);
    logic bit_v;
    for (int i = 7; i >= -1; i--) begin
      bit_v = (i < 0) ? 1'b1 : b[i];
      step(1'b0, d_now);
      step(1'b0, bit_v);
      step(1'b1, bit_v);
    end
  endtask
  // Clock stands at its idle level outside the frame; sample on shift edges
  task automatic spi_frame(input logic rise, output logic [7:0] got);
    got = 8'h00;
    for (int i = 0; i < 16; i++) begin
      #7.5 sck = ~sck;
      #3;
      if (sck == rise) got = {got[6:0], sdo_q};
      #4.5;
    end
  endtask
endmodule // bus_peer
`default_nettype wire

// ### verification/tb_serial_port_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_status_flags
  import serial_port_status_pkg::*;
;
  logic       clk, rst, master_tx_busy, tx_load, tx_busy_q, sck, sdo_q, scl, sda;
  config_s    cfg;
  status_s    status_q;
  logic [6:0] own_address;
  logic [7:0] tx_data;
  int         fail_count, n_compared;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1'b1; cfg = config_s'(5'h18); own_address = 7'h5a;
    master_tx_busy = 1'b0; tx_data = 8'h00; tx_load = 1'b0;
    fail_count = 0; n_compared = 0;
  end
  serial_port_status_flags dut (.clk(clk), .rst(rst), .cfg(cfg), .own_address(own_address),
    .master_tx_busy(master_tx_busy), .tx_data(tx_data), .tx_load(tx_load),
    .tx_busy_q(tx_busy_q), .sck(sck), .sdo_q(sdo_q), .scl_in(scl), .sda_in(sda),
    .status_q(status_q));
  bus_peer peer (.clk(clk), .rst(rst), .idle(cfg.clock_idle_polarity), .sdo_q(sdo_q),
    .sck(sck), .scl(scl), .sda(sda));
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Flags settle three to four cycles after the last pin move
  task automatic chk_flags(input logic [3:0] exp);
    repeat (6) @(posedge clk);
    #1;
    chk_byte({4'h0, status_q}, {4'h0, exp});
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    fail_count++;
    report_and_stop();
  end
  initial begin
    logic [7:0] got;
    logic       pol, cke;
    for (int k = 0; k < 4; k++) begin
      pol = k[1];
      cke = k[0];
      @(posedge clk);
      cfg <= config_s'({3'h4, pol, cke});
      do_reset();
      tx_data <= 8'h96 + 8'(k);
      tx_load <= 1'b1;
      @(posedge clk);
      tx_load <= 1'b0;
      @(posedge clk);
      #1 chk_byte({7'h00, tx_busy_q}, 8'h01);
      peer.spi_frame(pol ^ cke, got);
      chk_byte(got, 8'h96 + 8'(k));
      repeat (8) @(posedge clk);
      #1 chk_byte({7'h00, tx_busy_q}, 8'h00);
    end
    $display("test spi edges done");
    @(posedge clk);
    cfg <= config_s'(5'h18);
    do_reset();
    chk_flags(4'h0);
    peer.start_cond();
    chk_flags(4'h2);
    peer.i2c_byte(8'hb5);
    chk_flags(4'h3);
    peer.i2c_byte(8'h3c);
    chk_flags(4'hb);
    peer.stop_cond();
    chk_flags(4'hd);
    peer.start_cond();
    peer.i2c_byte(8'hb4);
    chk_flags(4'h2);
    @(posedge clk);
    cfg <= config_s'(5'h08);
    chk_flags(4'h0);
    $display("test i2c slave flags done");
    @(posedge clk);
    cfg <= config_s'(5'h1c);
    master_tx_busy <= 1'b1;
    chk_flags(4'h1);
    @(posedge clk);
    master_tx_busy <= 1'b0;
    chk_flags(4'h0);
    $display("test i2c master flag done");
    report_and_stop();
  end
endmodule // tb_serial_port_status_flags
`default_nettype wire
